/* File: pkg/bch_pkg.sv */
// package: register map, field layout and constants of the bridge header bank
package bch_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] BCH_OFS_CLASS    = 8'h08;
   localparam logic [7:0] BCH_OFS_HDR      = 8'h0C;
   localparam logic [7:0] BCH_OFS_BUS      = 8'h18;
   localparam logic [7:0] BCH_OFS_IO       = 8'h1C;
   localparam logic [7:0] BCH_OFS_IO_UPPER = 8'h30;
   // ---------------------------------------------------------------
   // fixed field values
   // ---------------------------------------------------------------
   localparam logic [7:0] BCH_PROG_IF      = 8'h00;
   localparam logic [7:0] BCH_SUB_CLASS    = 8'h04;
   localparam logic [7:0] BCH_BASE_CLASS   = 8'h06;
   localparam logic [7:0] BCH_LAYOUT_TYPE  = 8'h01;
   localparam logic [3:0] BCH_IO_32BIT     = 4'h1;
   // revision byte shares the class word; value is arbitrary
   localparam logic [7:0] BCH_REVISION     = 8'h00;
   // ---------------------------------------------------------------
   // reset values and bounds
   // ---------------------------------------------------------------
   localparam logic [7:0]  BCH_RST_BYTE    = 8'h00;
   localparam logic [3:0]  BCH_RST_NIB     = 4'h0;
   localparam logic [15:0] BCH_RST_UPPER   = 16'h0000;
   localparam logic [11:0] BCH_LOW_FILL    = 12'h000;
   localparam logic [11:0] BCH_HIGH_FILL   = 12'hFFF;
   localparam logic [7:0]  BCH_CNT_ZERO    = 8'h00;
endpackage : bch_pkg

/* File: rtl/bch_lat_cnt.sv */
// latency down-counter loaded from a timer register
`timescale 1ns/1ns
`default_nettype none
module bch_lat_cnt
   import bch_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_nrst,
   input  wire logic       i_start,
   input  wire logic       i_stop,
   input  wire logic [7:0] i_load,
   output logic            o_expired
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       run;
      logic       exp;
   } bch_lat_t;

   bch_lat_t st_r;
   bch_lat_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (i_stop)
      begin
         st_nxt.run = 1'b0;
         st_nxt.exp = 1'b0;
      end
      else if (i_start)
      begin
         st_nxt.cnt = i_load;
         st_nxt.run = 1'b1;
         st_nxt.exp = (i_load == BCH_CNT_ZERO);
      end
      else if (st_r.run && st_r.cnt != BCH_CNT_ZERO)
      begin
         st_nxt.cnt = st_r.cnt - 8'h01;
         st_nxt.exp = (st_r.cnt == 8'h01);
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_expired = st_r.exp;
endmodule : bch_lat_cnt
`default_nettype wire

/* File: rtl/bch_regs.sv */
// bridge configuration header bank with apb slave and window decode
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - programming interface byte always reads zero
// - sub-class byte reads fixed 04h, writes ignored
// - base-class byte reads fixed 06h, writes ignored
// - upstream latency value loads master counter started at frame assertion
// - layout type byte reads fixed 01h
// - writable upstream bus number, reset zero
// - writable downstream bus number, reset zero
// - writable highest downstream bus number, reset zero
// - downstream latency counts clocks to detect unclaimed accesses
// - io base and limit low nibbles read 1 for 32-bit io
// - io base nibble gives bits 15:12 of lower bound, rest zero
// - io limit nibble gives bits 15:12 of upper bound, rest ones
// - bits 31:16 of bounds come from separate upper registers
// - io forward decision compares address against base and limit
module bch_regs
   import bch_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_up_frame_start,
   input  wire logic        i_up_frame_end,
   input  wire logic        i_dn_frame_start,
   input  wire logic        i_dn_claimed,
   input  wire logic [31:0] i_io_addr,
   input  wire logic [5:0]  i_burst_words,
   output logic             o_up_lat_expired,
   output logic             o_dn_unclaimed,
   output logic             o_io_forward,
   output logic             o_line_end,
   output logic [7:0]       o_prefetch_words,
   output logic [7:0]       o_up_bus,
   output logic [7:0]       o_dn_bus,
   output logic [7:0]       o_sub_bus
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  line_size;
      logic [7:0]  up_lat;
      logic [7:0]  up_bus;
      logic [7:0]  dn_bus;
      logic [7:0]  sub_bus;
      logic [7:0]  dn_lat;
      logic [3:0]  io_base;
      logic [3:0]  io_limit;
      logic [15:0] io_base_hi;
      logic [15:0] io_limit_hi;
      logic [31:0] rdata;
      logic        fwd;
   } bch_state_t;

   bch_state_t st_r;
   bch_state_t st_nxt;

   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic [31:0] rd_word;
   logic [31:0] io_lo;
   logic [31:0] io_hi;
   logic        dn_expired;

   // single-cycle access phase: no wait states
   assign o_pready = i_psel && i_penable;
   assign wr_en    = o_pready && i_pwrite;
   assign rd_en    = o_pready && !i_pwrite;

   // ---------------------------------------------------------------
   // window bounds
   // ---------------------------------------------------------------
   assign io_lo = {st_r.io_base_hi, st_r.io_base, BCH_LOW_FILL};
   assign io_hi = {st_r.io_limit_hi, st_r.io_limit, BCH_HIGH_FILL};

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb
   begin
      mapped  = 1'b1;
      rd_word = 32'h0000_0000;
      case (i_paddr)
         BCH_OFS_CLASS:
            rd_word = {BCH_BASE_CLASS, BCH_SUB_CLASS, BCH_PROG_IF,
                       BCH_REVISION};
         BCH_OFS_HDR:
            rd_word = {8'h00, BCH_LAYOUT_TYPE, st_r.up_lat,
                       st_r.line_size};
         BCH_OFS_BUS:
            rd_word = {st_r.dn_lat, st_r.sub_bus, st_r.dn_bus, st_r.up_bus};
         BCH_OFS_IO:
            rd_word = {16'h0000, st_r.io_limit, BCH_IO_32BIT,
                       st_r.io_base, BCH_IO_32BIT};
         BCH_OFS_IO_UPPER:
            rd_word = {st_r.io_limit_hi, st_r.io_base_hi};
         default:
            mapped = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // register update
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // read-only fields have no storage, so writes to them fall away
      if (wr_en)
      begin
         case (i_paddr)
            BCH_OFS_HDR:
            begin
               if (i_pstrb[0])
                  st_nxt.line_size = i_pwdata[7:0];
               if (i_pstrb[1])
                  st_nxt.up_lat = i_pwdata[15:8];
            end
            BCH_OFS_BUS:
            begin
               if (i_pstrb[0])
                  st_nxt.up_bus = i_pwdata[7:0];
               if (i_pstrb[1])
                  st_nxt.dn_bus = i_pwdata[15:8];
               if (i_pstrb[2])
                  st_nxt.sub_bus = i_pwdata[23:16];
               if (i_pstrb[3])
                  st_nxt.dn_lat = i_pwdata[31:24];
            end
            BCH_OFS_IO:
            begin
               if (i_pstrb[0])
                  st_nxt.io_base = i_pwdata[7:4];
               if (i_pstrb[1])
                  st_nxt.io_limit = i_pwdata[15:12];
            end
            BCH_OFS_IO_UPPER:
            begin
               if (i_pstrb[0])
                  st_nxt.io_base_hi[7:0] = i_pwdata[7:0];
               if (i_pstrb[1])
                  st_nxt.io_base_hi[15:8] = i_pwdata[15:8];
               if (i_pstrb[2])
                  st_nxt.io_limit_hi[7:0] = i_pwdata[23:16];
               if (i_pstrb[3])
                  st_nxt.io_limit_hi[15:8] = i_pwdata[31:24];
            end
            default:
               st_nxt.line_size = st_r.line_size;
         endcase
      end
      if (o_pready)
      begin
         st_nxt.rdata  = rd_en ? rd_word : st_r.rdata;
      end
      // registered decode: one cycle behind the address
      st_nxt.fwd = (i_io_addr >= io_lo) && (i_io_addr <= io_hi);
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_r             <= '0;
         st_r.line_size   <= BCH_RST_BYTE;
         st_r.up_lat      <= BCH_RST_BYTE;
         st_r.up_bus      <= BCH_RST_BYTE;
         st_r.dn_bus      <= BCH_RST_BYTE;
         st_r.sub_bus     <= BCH_RST_BYTE;
         st_r.dn_lat      <= BCH_RST_BYTE;
         st_r.io_base     <= BCH_RST_NIB;
         st_r.io_limit    <= BCH_RST_NIB;
         st_r.io_base_hi  <= BCH_RST_UPPER;
         st_r.io_limit_hi <= BCH_RST_UPPER;
      end
      else
         st_r <= st_nxt;
   end

   // read data is held until the next read; slverr is combined with the access
   assign o_prdata  = rd_en ? rd_word : st_r.rdata;
   assign o_pslverr = o_pready && !mapped;

   // ---------------------------------------------------------------
   // latency counters
   // ---------------------------------------------------------------
   bch_lat_cnt u_up_lat
   (
      .i_mclk    (i_mclk),
      .i_nrst    (i_nrst),
      .i_start   (i_up_frame_start),
      .i_stop    (i_up_frame_end),
      .i_load    (st_r.up_lat),
      .o_expired (o_up_lat_expired)
   );

   bch_lat_cnt u_dn_lat
   (
      .i_mclk    (i_mclk),
      .i_nrst    (i_nrst),
      .i_start   (i_dn_frame_start),
      .i_stop    (i_dn_claimed),
      .i_load    (st_r.dn_lat),
      .o_expired (dn_expired)
   );

   assign o_dn_unclaimed = dn_expired;

   // ---------------------------------------------------------------
   // cache line use
   // ---------------------------------------------------------------
   // size zero disables line termination; invalid sizes are not policed
   assign o_line_end = (st_r.line_size != BCH_CNT_ZERO) &&
                       ({2'b00, i_burst_words} == st_r.line_size);
   assign o_prefetch_words = st_r.line_size;
   assign o_io_forward     = st_r.fwd;
   assign o_up_bus         = st_r.up_bus;
   assign o_dn_bus         = st_r.dn_bus;
   assign o_sub_bus        = st_r.sub_bus;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_class_fixed;
      @(posedge i_mclk) disable iff (!i_nrst)
      rd_en && i_paddr == BCH_OFS_CLASS |-> o_prdata[31:8] == 24'h060400;
   endproperty
   a_class_fixed: assert property (p_class_fixed)
      else $error("class code read wrong");

   property p_sub_class;
      @(posedge i_mclk) disable iff (!i_nrst)
      rd_en && i_paddr == BCH_OFS_CLASS |-> o_prdata[23:16] == 8'h04;
   endproperty
   a_sub_class: assert property (p_sub_class)
      else $error("sub-class read wrong");

   property p_base_class;
      @(posedge i_mclk) disable iff (!i_nrst)
      rd_en && i_paddr == BCH_OFS_CLASS |-> o_prdata[31:24] == 8'h06;
   endproperty
   a_base_class: assert property (p_base_class)
      else $error("base class read wrong");

   property p_line_write;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_HDR && i_pstrb[0]
         |=> o_prefetch_words == $past(i_pwdata[7:0]);
   endproperty
   a_line_write: assert property (p_line_write)
      else $error("cache line size not stored");

   property p_up_lat;
      @(posedge i_mclk) disable iff (!i_nrst)
      i_up_frame_start && !i_up_frame_end && st_r.up_lat == 8'h03
         ##1 !i_up_frame_end [*3] |=> o_up_lat_expired;
   endproperty
   a_up_lat: assert property (p_up_lat)
      else $error("upstream latency timing wrong");

   property p_layout;
      @(posedge i_mclk) disable iff (!i_nrst)
      rd_en && i_paddr == BCH_OFS_HDR |-> o_prdata[23:16] == 8'h01;
   endproperty
   a_layout: assert property (p_layout)
      else $error("layout type read wrong");

   property p_bus_nums;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_BUS && i_pstrb[2:0] == 3'h7
         |=> {o_sub_bus, o_dn_bus, o_up_bus} == $past(i_pwdata[23:0]);
   endproperty
   a_bus_nums: assert property (p_bus_nums)
      else $error("bus numbers not stored");

   property p_dn_zero;
      @(posedge i_mclk) disable iff (!i_nrst)
      i_dn_frame_start && !i_dn_claimed && st_r.dn_lat == 8'h00 |=> o_dn_unclaimed;
   endproperty
   a_dn_zero: assert property (p_dn_zero)
      else $error("unclaimed detect wrong");

   property p_io_nibble;
      @(posedge i_mclk) disable iff (!i_nrst)
      rd_en && i_paddr == BCH_OFS_IO |-> o_prdata[3:0] == 4'h1 && o_prdata[11:8] == 4'h1;
   endproperty
   a_io_nibble: assert property (p_io_nibble)
      else $error("io indicator wrong");

   property p_io_fwd;
      @(posedge i_mclk) disable iff (!i_nrst)
      i_nrst |=> o_io_forward ==
         ($past(i_io_addr) >= $past(io_lo) && $past(i_io_addr) <= $past(io_hi));
   endproperty
   a_io_fwd: assert property (p_io_fwd)
      else $error("io forward decode wrong");

   property p_io_lower;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_IO && i_pstrb[0]
         |=> io_lo[15:0] == {$past(i_pwdata[7:4]), 12'h000};
   endproperty
   a_io_lower: assert property (p_io_lower)
      else $error("io lower bound wrong");

   property p_io_upper;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_IO && i_pstrb[1]
         |=> io_hi[15:0] == {$past(i_pwdata[15:12]), 12'hFFF};
   endproperty
   a_io_upper: assert property (p_io_upper)
      else $error("io upper bound wrong");

   property p_io_hi16;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_IO_UPPER && i_pstrb == 4'hF
         |=> io_lo[31:16] == $past(i_pwdata[15:0]) && io_hi[31:16] == $past(i_pwdata[31:16]);
   endproperty
   a_io_hi16: assert property (p_io_hi16)
      else $error("io upper halves wrong");

   property p_ro_write;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_CLASS
         |=> $stable({st_r.line_size, st_r.up_lat, st_r.up_bus, st_r.dn_bus, st_r.dn_lat});
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("read-only write disturbed storage");

   property p_dn_lane;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_en && i_paddr == BCH_OFS_BUS && i_pstrb == 4'h2
         |=> o_dn_bus == $past(i_pwdata[15:8]) && $stable(o_up_bus) && $stable(o_sub_bus);
   endproperty
   a_dn_lane: assert property (p_dn_lane)
      else $error("downstream bus lane write wrong");
endmodule : bch_regs
`default_nettype wire

/* File: test/testbench.sv */
// self-checking testbench for the bridge header register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module testbench
   import bch_pkg::*;
;
   logic        mclk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        up_start;
   logic        up_end;
   logic        dn_start;
   logic        dn_claimed;
   logic [31:0] io_addr;
   logic [5:0]  burst_words;
   logic        up_exp;
   logic        dn_unc;
   logic        io_fwd;
   logic        line_end;
   logic [7:0]  pf_words;
   logic [7:0]  up_bus;
   logic [7:0]  dn_bus;
   logic [7:0]  sub_bus;
   int          err_count;
   int          checks;

   bch_regs dut (
      .i_mclk           (mclk),
      .i_nrst           (nrst),
      .i_psel           (psel),
      .i_penable        (penable),
      .i_pwrite         (pwrite),
      .i_paddr          (paddr),
      .i_pwdata         (pwdata),
      .i_pstrb          (pstrb),
      .o_prdata         (prdata),
      .o_pready         (pready),
      .o_pslverr        (pslverr),
      .i_up_frame_start (up_start),
      .i_up_frame_end   (up_end),
      .i_dn_frame_start (dn_start),
      .i_dn_claimed     (dn_claimed),
      .i_io_addr        (io_addr),
      .i_burst_words    (burst_words),
      .o_up_lat_expired (up_exp),
      .o_dn_unclaimed   (dn_unc),
      .o_io_forward     (io_fwd),
      .o_line_end       (line_end),
      .o_prefetch_words (pf_words),
      .o_up_bus         (up_bus),
      .o_dn_bus         (dn_bus),
      .o_sub_bus        (sub_bus)
   );

   always #10 mclk = ~mclk;

   // ---------------------------------------------------------------
   // bus and stimulus tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rdat, output logic err);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, s, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
      `CHK(r, exp)
      `CHK(e, experr)
   endtask : rd

   // edges counted from the one that samples the start pulse
   task automatic lat_run(input bit dn, input int l);
      int n;
      n = 0;
      @(posedge mclk);
      if (dn)
         dn_start <= 1'b1;
      else
         up_start <= 1'b1;
      @(posedge mclk);
      dn_start <= 1'b0;
      up_start <= 1'b0;
      #1;
      while (((dn ? dn_unc : up_exp) !== 1'b1) && n < 300)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n, l)
      @(posedge mclk);
      dn_claimed <= dn;
      up_end     <= !dn;
      @(posedge mclk);
      dn_claimed <= 1'b0;
      up_end     <= 1'b0;
      #1;
      `CHK({up_exp, dn_unc}, 2'b00)
   endtask : lat_run

   task automatic io(input logic [31:0] a, input logic exp);
      @(posedge mclk);
      io_addr <= a;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(io_fwd, exp)
   endtask : io

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial
   begin
      {mclk, nrst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {up_start, up_end, dn_start, dn_claimed, io_addr, burst_words} = '0;
      err_count = 0;
      checks    = 0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rd(BCH_OFS_CLASS, {BCH_BASE_CLASS, BCH_SUB_CLASS, BCH_PROG_IF, BCH_REVISION});
      rd(BCH_OFS_HDR, {8'h00, BCH_LAYOUT_TYPE, 16'h0000});
      rd(BCH_OFS_BUS, 32'h0000_0000);
      rd(BCH_OFS_IO, 32'h0000_0101);
      wr(BCH_OFS_CLASS, 32'hFFFF_FFFF, 4'hF);
      rd(BCH_OFS_CLASS, {BCH_BASE_CLASS, BCH_SUB_CLASS, BCH_PROG_IF, BCH_REVISION});
      wr(BCH_OFS_HDR, 32'hFFFF_0310, 4'hF);
      rd(BCH_OFS_HDR, 32'h0001_0310);
      `CHK(pf_words, 8'h10)
      burst_words <= 6'h10;
      @(posedge mclk);
      #1;
      `CHK(line_end, 1'b1)
      @(posedge mclk);
      burst_words <= 6'h0F;
      @(posedge mclk);
      #1;
      `CHK(line_end, 1'b0)
      wr(BCH_OFS_BUS, 32'h4007_0201, 4'hF);
      @(posedge mclk);
      `CHK({sub_bus, dn_bus, up_bus}, 24'h07_0201)
      // one lane only: neighbours must keep their values
      wr(BCH_OFS_BUS, 32'hFFFF_AAFF, 4'b0010);
      rd(BCH_OFS_BUS, 32'h4007_AA01);
      lat_run(1'b0, 3);
      lat_run(1'b1, 64);
      // claimed early: the unclaimed flag must stay low
      @(posedge mclk);
      dn_start <= 1'b1;
      @(posedge mclk);
      dn_start <= 1'b0;
      repeat (3) @(posedge mclk);
      dn_claimed <= 1'b1;
      @(posedge mclk);
      dn_claimed <= 1'b0;
      repeat (80) @(posedge mclk);
      #1;
      `CHK(dn_unc, 1'b0)
      wr(BCH_OFS_IO, 32'hFFFF_3F2F, 4'hF);
      rd(BCH_OFS_IO, 32'h0000_3121);
      io(32'h0000_1FFF, 1'b0);
      io(32'h0000_2000, 1'b1);
      io(32'h0000_3FFF, 1'b1);
      io(32'h0000_4000, 1'b0);
      io(32'h0001_2000, 1'b0);
      wr(BCH_OFS_IO_UPPER, 32'h0001_0001, 4'hF);
      io(32'h0001_2000, 1'b1);
      io(32'h0001_3FFF, 1'b1);
      io(32'h0000_2000, 1'b0);
      io(32'h0001_4000, 1'b0);
      // unmapped offset: error response, zero data
      rd(8'h04, 32'h0000_0000, 1'b1);
      // second reset in mid-run
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rd(BCH_OFS_BUS, 32'h0000_0000);
      rd(BCH_OFS_HDR, {8'h00, BCH_LAYOUT_TYPE, 16'h0000});
      `CHK({sub_bus, dn_bus, up_bus, pf_words}, 32'h0000_0000)
      // zero timer after reset: unclaimed flag on the edge after start
      lat_run(1'b1, 0);
      conclude();
   end

   // run needs well under 2000 cycles
   initial
   begin
      #(20 * 20000);
      err_count++;
      conclude();
   end
endmodule : testbench
`undef CHK
`default_nettype wire
